// ==== design/keypad_parameter_menu_editor.v ====
// Keypad menu navigation, value editing, password gate and AXI4-Lite slave
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "keypad_defs.vh"

// Behaviour
// RULE1: Menu toggles tree and monitor, applies changes
// RULE2: User-group edit committed to retained memory
// RULE3: Unsaved other edits revert after power cycle
// RULE4: Running: up raises, down lowers speed
// RULE5: Running: sideways keys step display lines
// RULE6: Idle: arrows walk parameter tree, edit values
// RULE7: Nonzero password locks all but user group
// RULE8: Three-digit groups; control group 200 to 359
// RULE9: Maximum speed clamped to 50.00..100.00 percent
// RULE10: Lower-left field shows parameter number
// RULE11: Cursor over adjust symbol and digits
// RULE12: Cursor on adjust: fast whole-value change
// RULE13: Adjust-symbol change acts on motor immediately; the code does so only for slots 0-3 and 5 (padj)
// RULE14: Digit edits held until cursor returns
// RULE15: Save prompt yes/no after user edit
// RULE16: Menu on yes saves all, shows message
// RULE17: Diagnostic check before power indicator
// RULE18: Two display lines of sixteen characters
// RULE19: Keys debounced into one-cycle press events
module keypad_parameter_menu_editor #(
	parameter                  DEBOUNCE_CYCLES = `KEY_DEBOUNCE_CYCLES,
	parameter                  SAVE_MSG_CYCLES = `SAVE_MSG_CYCLES
) (
	input  wire                aclk,
	input  wire                aresetn,
	input  wire [4:0]          keys_n,
	input  wire                motor_running,
	input  wire [4:0]          s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output wire                s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output wire                s_axi_wready,
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	input  wire [4:0]          s_axi_araddr,
	input  wire                s_axi_arvalid,
	output wire                s_axi_arready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	output reg                 power_led,
	output reg  [15:0]         speed_cmd,
	output reg  [2:0]          disp_mode,
	output reg  [3:0]          disp_top_sel,
	output reg  [3:0]          disp_bottom_sel,
	output reg  [9:0]          disp_param_num,
	output reg  [15:0]         disp_value,
	output reg  [2:0]          disp_cursor,
	output reg                 save_yes,
	output reg                 apply_stb,
	output reg  [9:0]          apply_num,
	output reg  [15:0]         apply_value
);

	// =================================================================
	// States
	localparam [2:0] ST_DIAG    = 3'h0;
	localparam [2:0] ST_MONITOR = 3'h1;
	localparam [2:0] ST_BROWSE  = 3'h2;
	localparam [2:0] ST_EDIT    = 3'h3;
	localparam [2:0] ST_PROMPT  = 3'h4;
	localparam [2:0] ST_SAVING  = 3'h5;

	// =================================================================
	// Parameter table: number, limits, factory value, flags
	function [9:0] pnum(input [2:0] s);
		case (s)
			3'h0: pnum = 10'h000;
			3'h1: pnum = 10'h001;
			3'h2: pnum = 10'h078;
			3'h3: pnum = 10'h079;     // 121
			3'h4: pnum = 10'h0fa;
			3'h5: pnum = 10'h154;
			3'h6: pnum = 10'h35c;     // 860
			default: pnum = 10'h35d;
		endcase
	endfunction
	function [15:0] pmin(input [2:0] s);
		case (s)
			3'h3: pmin = 16'h1388;    // RULE9
			3'h4: pmin = 16'h0001;
			default: pmin = 16'h0000;
		endcase
	endfunction
	function [15:0] pmax(input [2:0] s);
		case (s)
			3'h2: pmax = 16'h1d4c;
			3'h3: pmax = 16'h2710;    // RULE9
			3'h4: pmax = 16'h4a38;
			3'h5: pmax = 16'h4e20;
			3'h6: pmax = 16'h270f;
			3'h7: pmax = 16'h270f;
			default: pmax = 16'h2710;
		endcase
	endfunction
	function [15:0] pfac(input [2:0] s);
		case (s)
			3'h3: pfac = 16'h2710;
			3'h4: pfac = 16'h0064;
			3'h5: pfac = 16'h03e8;
			default: pfac = 16'h0000;
		endcase
	endfunction
	// User-group slots are 0..3
	function puser(input [2:0] s);
		puser = (s < 3'h4);
	endfunction
	// Slots whose adjust-symbol changes are applied at once, running or not
	function padj(input [2:0] s);
		padj = (s != 3'h4) && (s < 3'h6);
	endfunction
	function [15:0] dstep(input [2:0] c);
		case (c)
			3'h1: dstep = 16'h0001;
			3'h2: dstep = 16'h000a;
			3'h3: dstep = 16'h0064;
			3'h4: dstep = 16'h03e8;
			3'h5: dstep = 16'h2710;
			default: dstep = `FAST_STEP;  // RULE12
		endcase
	endfunction

	// =================================================================
	// Key events and motor-state synchroniser
	wire [4:0] press;
	reg        run_s1;
	reg        running;

	key_debounce #(
		.NKEYS  (`NUM_KEYS),
		.CYCLES (DEBOUNCE_CYCLES)
	) u_keys (
		.aclk    (aclk),
		.aresetn (aresetn),
		.keys_n  (keys_n),
		.press   (press)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			run_s1  <= 1'b0;
			running <= 1'b0;
		end else begin
			run_s1  <= motor_running;
			running <= run_s1;
		end
	end

	// =================================================================
	// Storage: live values, retained copy, per-slot saved marks
	reg [15:0] live [0:`NUM_SLOTS-1];
	reg [15:0] ret  [0:`NUM_SLOTS-1];
	reg [7:0]  ret_valid;
	// Blank retained storage at first power; reset does not touch it
	initial ret_valid = 8'h00;

	reg  [2:0]  state;
	reg  [2:0]  slot;
	reg  [2:0]  cursor;
	reg  [15:0] edit_val;
	reg  [24:0] tmr;
	reg  [3:0]  idx;
	reg         diag_fail;
	reg  [1:0]  ctrl;
	reg         nv_erase;
	reg  [2:0]  psel;
	wire [4:0]  ev = ctrl[`CTRL_KEYS_EN_BIT] ? press : 5'h00;
	wire        locked = (live[`SLOT_PW_SET] != 16'h0000) &&
	                     (live[`SLOT_PW_ENTRY] != live[`SLOT_PW_SET]);    // RULE7
	wire        may_edit = puser(slot) || (slot == `SLOT_PW_ENTRY) || !locked;    // RULE7
	wire [16:0] up_sum = {1'b0, edit_val} + {1'b0, dstep(cursor)};
	wire [15:0] ev_up = (up_sum > {1'b0, pmax(slot)}) ? pmax(slot) : up_sum[15:0];
	wire [15:0] ev_dn = (edit_val < pmin(slot) + dstep(cursor)) ?
	                    pmin(slot) : edit_val - dstep(cursor);
	wire [16:0] sp_sum = {1'b0, live[0]} + {1'b0, `SPEED_STEP};
	wire [15:0] sp_up = (sp_sum > {1'b0, live[`SLOT_MAX_SPEED]}) ?
	                    live[`SLOT_MAX_SPEED] : sp_sum[15:0];
	wire [15:0] sp_dn = (live[0] < `SPEED_STEP) ? 16'h0000 : live[0] - `SPEED_STEP;
	// Group code of the shown parameter: 1 marks the control group
	wire        in_ctrl_grp = (pnum(slot) >= `CTRL_GRP_LO) &&
	                          (pnum(slot) <= `CTRL_GRP_HI);    // RULE8

	// =================================================================
	// Menu state machine and value editor
	always @(posedge aclk) begin
		if (!aresetn) begin
			state           <= ST_DIAG;
			slot            <= 3'h0;
			cursor          <= 3'h0;
			edit_val        <= 16'h0000;
			tmr             <= 25'h0;
			idx             <= 4'h0;
			diag_fail       <= 1'b0;
			power_led       <= 1'b0;
			save_yes        <= 1'b1;
			apply_stb       <= 1'b0;
			apply_num       <= 10'h000;
			apply_value     <= 16'h0000;
			disp_top_sel    <= 4'h0;    // RULE18
			disp_bottom_sel <= 4'h1;    // RULE18
		end else begin
			apply_stb <= 1'b0;
			if (nv_erase)
				ret_valid <= 8'h00;
			case (state)
			ST_DIAG: begin
				// Reload live set and check the table before lighting power
				if (idx < `NUM_SLOTS) begin
					live[idx[2:0]] <= ret_valid[idx[2:0]] ? ret[idx[2:0]] :
					                  pfac(idx[2:0]);    // RULE3
					if (pfac(idx[2:0]) < pmin(idx[2:0]) || pfac(idx[2:0]) > pmax(idx[2:0]))
						diag_fail <= 1'b1;
					idx <= idx + 4'h1;
				end
				if (tmr >= `DIAG_CYCLES - 1) begin
					if (!diag_fail) begin
						power_led <= 1'b1;    // RULE17
						state     <= ST_MONITOR;
					end
				end else begin
					tmr <= tmr + 25'h1;
				end
			end
			ST_MONITOR: begin
				if (ev[`KEY_MENU]) begin
					state <= ST_BROWSE;    // RULE1
				end else if (running) begin
					// Speed and display control while driving the motor
					if (ev[`KEY_UP])
						live[0] <= sp_up;    // RULE4
					else if (ev[`KEY_DOWN])
						live[0] <= sp_dn;    // RULE4
					if (ev[`KEY_LEFT])
						disp_top_sel <= (disp_top_sel == `DISP_SEL_COUNT) ?
						                4'h0 : disp_top_sel + 4'h1;    // RULE5
					if (ev[`KEY_RIGHT])
						disp_bottom_sel <= (disp_bottom_sel == `DISP_SEL_COUNT) ?
						                   4'h0 : disp_bottom_sel + 4'h1;    // RULE5
				end
			end
			ST_BROWSE: begin
				if (ev[`KEY_MENU]) begin
					state <= ST_MONITOR;    // RULE1
				end else if (ev[`KEY_RIGHT]) begin
					slot <= slot + 3'h1;    // RULE6
				end else if (ev[`KEY_LEFT]) begin
					slot <= slot - 3'h1;    // RULE6
				end else if (ev[`KEY_UP] && may_edit) begin
					edit_val <= live[slot];    // RULE6
					cursor   <= 3'h0;
					state    <= ST_EDIT;
				end
			end
			ST_EDIT: begin
				if (ev[`KEY_MENU]) begin
					// Commit: the controller acts on the new value
					live[slot]  <= edit_val;    // RULE1
					apply_stb   <= 1'b1;
					apply_num   <= pnum(slot);
					apply_value <= edit_val;
					if (puser(slot)) begin
						ret[slot]       <= edit_val;    // RULE2
						ret_valid[slot] <= 1'b1;
						save_yes        <= 1'b1;
						state           <= ST_PROMPT;    // RULE15
					end else begin
						state <= ST_BROWSE;
					end
				end else if (ev[`KEY_LEFT] && cursor < `CURSOR_MAX) begin
					cursor <= cursor + 3'h1;    // RULE11
				end else if (ev[`KEY_RIGHT] && cursor != 3'h0) begin
					cursor <= cursor - 3'h1;    // RULE11
					if (cursor == 3'h1) begin
						// Back on the adjust symbol: held digit edits take effect
						live[slot]  <= edit_val;    // RULE14
						apply_stb   <= 1'b1;
						apply_num   <= pnum(slot);
						apply_value <= edit_val;
					end
				end else if (ev[`KEY_UP] || ev[`KEY_DOWN]) begin
					edit_val <= ev[`KEY_UP] ? ev_up : ev_dn;    // RULE11
					if (cursor == 3'h0 && padj(slot)) begin
						live[slot]  <= ev[`KEY_UP] ? ev_up : ev_dn;    // RULE13
						apply_stb   <= 1'b1;
						apply_num   <= pnum(slot);
						apply_value <= ev[`KEY_UP] ? ev_up : ev_dn;
					end
				end
			end
			ST_PROMPT: begin
				if (ev[`KEY_UP] || ev[`KEY_DOWN]) begin
					save_yes <= ~save_yes;    // RULE15
				end else if (ev[`KEY_MENU]) begin
					idx   <= 4'h0;
					tmr   <= 25'h0;
					state <= save_yes ? ST_SAVING : ST_BROWSE;    // RULE15
				end
			end
			ST_SAVING: begin
				// Copy every slot, then hold the message before returning
				if (idx < `NUM_SLOTS) begin
					ret[idx[2:0]]       <= live[idx[2:0]];    // RULE16
					ret_valid[idx[2:0]] <= 1'b1;
					idx                 <= idx + 4'h1;
				end else if (tmr >= SAVE_MSG_CYCLES - 1) begin
					state <= ST_BROWSE;    // RULE16
				end else begin
					tmr <= tmr + 25'h1;
				end
			end
			default: state <= ST_DIAG;
			endcase
		end
	end

	// =================================================================
	// Display fields; lower-left carries the number, never the value
	always @(posedge aclk) begin
		if (!aresetn) begin
			disp_mode      <= ST_DIAG;
			disp_param_num <= 10'h000;
			disp_value     <= 16'h0000;
			disp_cursor    <= 3'h0;
			speed_cmd      <= 16'h0000;
		end else begin
			disp_mode      <= state;
			disp_param_num <= pnum(slot);    // RULE10
			disp_value     <= (state == ST_EDIT) ? edit_val : live[slot];
			disp_cursor    <= cursor;
			speed_cmd      <= (state == ST_DIAG) ? 16'h0000 : live[0];
		end
	end

	// =================================================================
	// AXI4-Lite slave: one write and one read at a time
	reg        aw_held;
	reg        w_held;
	reg [4:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Address and data may come in either order; answer once both held
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 5'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			ctrl         <= `CTRL_RESET;
			nv_erase     <= 1'b0;
			psel         <= 3'h0;
		end else begin
			nv_erase <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				case (aw_addr)
				`REG_CTRL: begin
					if (w_strb[0]) begin
						ctrl[`CTRL_KEYS_EN_BIT] <= w_data[`CTRL_KEYS_EN_BIT];
						nv_erase                <= w_data[`CTRL_NV_ERASE_BIT];
					end
				end
				`REG_PSEL: begin
					if (w_strb[0])
						psel <= w_data[2:0];
				end
				`REG_STATUS, `REG_PDATA, `REG_SPEED: ;
				default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read data captured on the same edge that takes the address
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			case (s_axi_araddr)
			`REG_CTRL:   s_axi_rdata <= {30'h0, 1'b0, ctrl[`CTRL_KEYS_EN_BIT]};
			`REG_STATUS: s_axi_rdata <= {17'h0, in_ctrl_grp, save_yes, slot, cursor,
			                             diag_fail, running, power_led, locked, state};
			`REG_PSEL:   s_axi_rdata <= {29'h0, psel};
			`REG_PDATA:  s_axi_rdata <= {16'h0000, live[psel]};
			`REG_SPEED:  s_axi_rdata <= {16'h0000, speed_cmd};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // keypad_parameter_menu_editor

// ==== design/keypad_defs.vh ====
// Shared constants of the keypad parameter menu editor
`ifndef KEYPAD_DEFS_VH
`define KEYPAD_DEFS_VH

// =====================================================================
// Clock and timing
`define CLK_MHZ             10
`define DIAG_US             100
`define DIAG_CYCLES         (`DIAG_US * `CLK_MHZ)
`define KEY_DEBOUNCE_US     10000
`define KEY_DEBOUNCE_CYCLES (`KEY_DEBOUNCE_US * `CLK_MHZ)
`define SAVE_MSG_MS         2000
`define SAVE_MSG_CYCLES     (`SAVE_MSG_MS * 1000 * `CLK_MHZ)

// =====================================================================
// Key indices
`define KEY_MENU  0
`define KEY_UP    1
`define KEY_DOWN  2
`define KEY_LEFT  3
`define KEY_RIGHT 4
`define NUM_KEYS  5

// =====================================================================
// Display and parameter layout
`define DISP_COLS      16
`define DISP_SEL_COUNT 4'hf
`define NUM_SLOTS      8
`define SLOT_RUN_SPEED 3'h0
`define SLOT_MAX_SPEED 3'h3
`define SLOT_PW_SET    3'h6
`define SLOT_PW_ENTRY  3'h7
`define CTRL_GRP_LO    10'h0c8
`define CTRL_GRP_HI    10'h167
`define FAST_STEP      16'h0064
`define SPEED_STEP     16'h0064
`define CURSOR_MAX     3'h5

// =====================================================================
// AXI4-Lite register map (byte addresses) and fields
`define REG_CTRL   5'h00
`define REG_STATUS 5'h04
`define REG_PSEL   5'h08
`define REG_PDATA  5'h0c
`define REG_SPEED  5'h10
`define CTRL_KEYS_EN_BIT 0
`define CTRL_NV_ERASE_BIT 1
`define CTRL_RESET 2'h1
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== design/key_debounce.v ====
// Key synchroniser, debouncer and press-pulse generator
`timescale 1ns/10ps
module key_debounce #(
	parameter                  NKEYS  = 5,
	parameter                  CYCLES = 100000
) (
	input  wire                aclk,
	input  wire                aresetn,
	input  wire [NKEYS-1:0]    keys_n,
	output wire [NKEYS-1:0]    press
);

	// =================================================================
	// One debouncer per key
	genvar k;
	generate
		for (k = 0; k < NKEYS; k = k + 1) begin : g_key
			reg        sync1;
			reg        sync2;
			reg        stable;
			reg        pulse;
			reg [23:0] cnt;

			// Two flops first, the key pin is asynchronous
			always @(posedge aclk) begin
				if (!aresetn) begin
					sync1 <= 1'b0;
					sync2 <= 1'b0;
				end else begin
					sync1 <= ~keys_n[k];
					sync2 <= sync1;
				end
			end

			// Accept a level only after it held for the full window
			always @(posedge aclk) begin
				if (!aresetn) begin
					stable <= 1'b0;
					pulse  <= 1'b0;
					cnt    <= 24'h000000;
				end else begin
					pulse <= 1'b0;
					if (sync2 == stable) begin
						cnt <= 24'h000000;
					end else if (cnt >= CYCLES - 1) begin
						cnt    <= 24'h000000;
						stable <= sync2;
						pulse  <= sync2;    // RULE19
					end else begin
						cnt <= cnt + 24'h000001;
					end
				end
			end
			assign press[k] = pulse;
		end
	endgenerate

endmodule // key_debounce

// ==== test/keypad_menu_monitor.sv ====
// Port checker of the keypad parameter menu editor
`timescale 1ns/10ps
module keypad_menu_monitor (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        power_led,
	input wire [15:0] speed_cmd,
	input wire [2:0]  disp_mode,
	input wire [2:0]  disp_cursor,
	input wire        apply_stb,
	input wire [9:0]  apply_num,
	input wire [15:0] apply_value
);
	// =====================================================================
	// Clocking and cycles since reset release
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int unsigned up_cnt;
	always @(posedge aclk) begin
		up_cnt <= !aresetn ? 0 : up_cnt + 1;
	end
	// =====================================================================
	// Keypad side
	diag_first_a: assert property ($rose(power_led) |-> up_cnt >= 998)
		else $error("indicator lit before diagnostic ended");
	led_monitor_a: assert property ($rose(power_led) |-> ##[0:2] disp_mode == 3'h1)
		else $error("no monitor display after diagnostic");
	led_steady_a: assert property ($past(power_led) |-> power_led)
		else $error("indicator dropped");
	apply_pulse_a: assert property (apply_stb |=> !apply_stb)
		else $error("apply strobe longer than one cycle");
	cursor_range_a: assert property (disp_cursor <= 3'h5)
		else $error("cursor past highest digit");
	max_clamp_a: assert property (apply_stb && apply_num == 10'h079 |->
		apply_value >= 16'h1388 && apply_value <= 16'h2710) else $error("max speed out of range");
	digit_hold_a: assert property (apply_stb |->
		##[0:2] (disp_cursor == 3'h0 || disp_mode != 3'h3)) else $error("digit edit applied");
	speed_cap_a: assert property (speed_cmd <= 16'h2710)
		else $error("speed above full scale");
	// =====================================================================
	// Register bus side
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken while response pending");
endmodule // keypad_menu_monitor

bind keypad_parameter_menu_editor keypad_menu_monitor u_mon (.*);

// ==== test/keypad_operator.sv ====
// Operator model: presses keypad keys one at a time
`timescale 1ns/10ps
module keypad_operator #(
	parameter         HOLD = 12
) (
	input  wire       aclk,
	output reg  [4:0] keys_n
);
	// Contacts at rest read high through their pull-ups
	initial keys_n = 5'h1f;
	// =====================================================================
	// Held well past the debounce time, then a full release gap
	task press(input int k, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge aclk);
			keys_n[k] <= 1'b0;
			repeat (HOLD) @(posedge aclk);
			keys_n[k] <= 1'b1;
			repeat (HOLD) @(posedge aclk);
		end
	endtask
endmodule // keypad_operator

// ==== test/keypad_parameter_menu_editor_bench.sv ====
// Self-checking bench of the keypad parameter menu editor
`timescale 1ns/10ps
`include "keypad_defs.vh"
module keypad_parameter_menu_editor_bench;
	// =====================================================================
	// Stimulus and observed signals
	reg         aclk = 0, aresetn = 0, motor_running = 0;
	reg  [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg         s_axi_arvalid = 0, s_axi_rready = 0;
	reg  [31:0] s_axi_wdata = 0;
	reg  [3:0]  s_axi_wstrb = 4'hf;
	wire [4:0]  keys_n;
	wire        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
	wire        power_led, save_yes, apply_stb;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] speed_cmd, disp_value, apply_value;
	wire [2:0]  disp_mode, disp_cursor;
	wire [3:0]  disp_top_sel, disp_bottom_sel;
	wire [9:0]  disp_param_num, apply_num;
	int         errors = 0, n_tests = 0, cycles = 0, n_apply = 0, a0;
	reg  [15:0] last_val;
	reg  [9:0]  last_num;
	reg  [31:0] rdat;
	reg  [1:0]  resp;

	// Short counts keep the run brief
	always #50 aclk = ~aclk;
	keypad_parameter_menu_editor #(.DEBOUNCE_CYCLES(4), .SAVE_MSG_CYCLES(8)) u_dut (.*);
	keypad_operator u_op (.aclk(aclk), .keys_n(keys_n));

	// Record every apply strobe for the edit checks
	always @(posedge aclk) begin
		if (apply_stb === 1'b1) begin
			n_apply <= n_apply + 1;
			last_val <= apply_value;
			last_num <= apply_num;
		end
	end
	// Hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test;
		end
	end
	// =====================================================================
	// Shared tasks
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task finish_test;
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Address and data offered together, each released when taken
	task wr(input [4:0] a, input [31:0] d);
		reg aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task rd(input [4:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task wait_mode(input [2:0] m);
		int i;
		for (i = 0; i < 200 && disp_mode !== m; i++) @(posedge aclk);
		chk("disp_mode", m, disp_mode);
	endtask
	// =====================================================================
	// Scenarios
	task t_reset;
		@(posedge aclk);
		aresetn <= 0;
		repeat (20) @(posedge aclk);
		chk("top_sel", 0, disp_top_sel);
		chk("bottom_sel", 1, disp_bottom_sel);
		aresetn <= 1;
		repeat (500) @(posedge aclk);
		chk("led early", 0, power_led);
		repeat (600) @(posedge aclk);
		chk("led", 1, power_led);
		chk("mode", 1, disp_mode);
		$display("t_reset done");
	endtask
	task t_regs;
		rd(`REG_CTRL);
		chk("ctrl", 1, rdat);
		rd(5'h14);
		chk("unmapped rresp", 2, resp);
		chk("unmapped rdata", 0, rdat);
		wr(5'h14, 32'h1);
		chk("unmapped bresp", 2, resp);
		rd(`REG_STATUS);
		chk("status", 32'h11, rdat & 32'h7f);
		wr(`REG_CTRL, 32'h0);
		chk("ctrl bresp", 0, resp);
		u_op.press(`KEY_MENU, 1);
		chk("keys off", 1, disp_mode);
		wr(`REG_CTRL, 32'h1);
		$display("t_regs done");
	endtask
	task t_edit;
		u_op.press(`KEY_MENU, 1);
		chk("browse", 2, disp_mode);
		u_op.press(`KEY_RIGHT, 3);
		chk("param", 121, disp_param_num);
		u_op.press(`KEY_UP, 1);
		chk("edit", 3, disp_mode);
		u_op.press(`KEY_LEFT, 5);
		chk("cursor", 5, disp_cursor);
		u_op.press(`KEY_DOWN, 1);
		chk("clamp", 5000, disp_value);
		u_op.press(`KEY_RIGHT, 1);
		a0 = n_apply;
		u_op.press(`KEY_UP, 1);
		chk("digit", 6000, disp_value);
		chk("held", a0, n_apply);
		u_op.press(`KEY_RIGHT, 4);
		chk("applied", a0 + 1, n_apply);
		chk("value", 6000, last_val);
		u_op.press(`KEY_UP, 1);
		chk("fast", 6100, last_val);
		chk("now", a0 + 2, n_apply);
		u_op.press(`KEY_MENU, 1);
		chk("prompt", 4, disp_mode);
		chk("commit", 121, last_num);
		chk("yes", 1, save_yes);
		u_op.press(`KEY_DOWN, 1);
		chk("no", 0, save_yes);
		u_op.press(`KEY_UP, 1);
		chk("yes again", 1, save_yes);
		fork
			u_op.press(`KEY_MENU, 1);
			wait_mode(3'h5);
		join
		wait_mode(3'h2);
		$display("t_edit done");
	endtask
	task t_revert;
		u_op.press(`KEY_RIGHT, 1);
		chk("param", 250, disp_param_num);
		rd(`REG_STATUS);
		chk("control group", 1, rdat[14]);
		u_op.press(`KEY_UP, 2);
		u_op.press(`KEY_MENU, 1);
		chk("accel", 250, last_num);
		chk("accel val", 200, last_val);
		// Commit a user value, then decline the save: back to browsing
		u_op.press(`KEY_LEFT, 1);
		u_op.press(`KEY_UP, 1);
		u_op.press(`KEY_MENU, 1);
		u_op.press(`KEY_DOWN, 1);
		u_op.press(`KEY_MENU, 1);
		chk("no returns", 2, disp_mode);
		t_reset;
		wr(`REG_PSEL, 32'h4);
		rd(`REG_PDATA);
		chk("factory", 100, rdat);
		wr(`REG_PSEL, 32'h3);
		rd(`REG_PDATA);
		chk("retained", 6100, rdat);
		// Erase retained marks: the next power-up falls back to factory
		wr(`REG_CTRL, 32'h3);
		t_reset;
		wr(`REG_PSEL, 32'h3);
		rd(`REG_PDATA);
		chk("erased", 32'h2710, rdat);
		$display("t_revert done");
	endtask
	task t_run;
		@(posedge aclk);
		motor_running <= 1;
		u_op.press(`KEY_UP, 2);
		chk("faster", 200, speed_cmd);
		rd(`REG_SPEED);
		chk("speed reg", 200, rdat);
		u_op.press(`KEY_DOWN, 3);
		chk("floor", 0, speed_cmd);
		u_op.press(`KEY_UP, 1);
		chk("single step", 100, speed_cmd);
		u_op.press(`KEY_LEFT, 1);
		chk("top", 1, disp_top_sel);
		u_op.press(`KEY_RIGHT, 1);
		chk("bottom", 2, disp_bottom_sel);
		$display("t_run done");
	endtask

	// Main sequence
	initial begin
		t_reset;
		t_regs;
		t_edit;
		t_revert;
		t_run;
		finish_test;
	end
endmodule // keypad_parameter_menu_editor_bench
